//--- rtl/timer8_compare_pulse_pwm.sv
// compare, single pulse and pwm section of an 8-bit free-running timer
// assumes software strobes and control bits come from logic on mclk, the
// capture pins and the second oscillator arrive asynchronously
`timescale 1ns/1ps
`default_nettype none

// How it works
// - a compare flag clears after a status read with it set, then a compare access
// - pin enable clear: pin released, flag and interrupt still work
// - at tick div 2 events happen when count equals the compare value
// - at other tick rates events happen when count equals compare value plus one
// - force bit copies the level bit to an enabled compare pin continuously
// - forcing the pin never sets a compare flag
// - force bits do nothing in single pulse or pwm mode
// - single pulse mode uses capture one and compare one
// - single pulse trigger presets count, drives second level, sets capture flag one
// - single pulse ends at compare one, pin takes the first level bit
// - single pulse: compare flag one never set, compare two flags only
// - pwm wins when both mode bits are set
// - single pulse: pin one never captures, pin two still captures
// - pwm compare values take new writes only at the compare two event
// - pwm compare two event reloads the counter preset
// - pwm pin takes first level at compare one, second at compare two
// - pwm never sets compare flags
// - pwm compare two event sets capture flag one
// - pwm ignores capture pin one, pin two still captures
// - wait mode leaves the timer alone, interrupt wakes the device
// - halt freezes counter and registers; interrupt wake resumes the held count
// - capture edge in halt arms; interrupt wake sets flag and captures count
// - tick select: 00 div 4, 01 div 2, 10 div 8, 11 second oscillator div 8000
// - pin enables gate the pins and the force bits, compare logic keeps running
module timer8_compare_pulse_pwm #(
	parameter int OSC2_DIV = timer8_pkg::OSC2_DIVIDE
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// configuration and software access
	input wire timer8_pkg::ctrl_t ctrl,
	input wire timer8_pkg::access_t acc,
	input wire logic [7:0] write_data,
	// power modes
	input wire logic halt,
	input wire logic wake_irq,
	// external pins
	input wire logic osc2_clk,
	input wire logic capture_pin_one,
	input wire logic capture_pin_two,
	output logic compare_out_pin_one,
	output logic compare_out_pin_one_oe_n,
	output logic compare_out_pin_two,
	output logic compare_out_pin_two_oe_n,
	// state seen by software
	output timer8_pkg::status_t status,
	output logic [7:0] count,
	output logic [7:0] compare_value_one,
	output logic [7:0] compare_value_two,
	output logic [7:0] capture_value_one,
	output logic [7:0] capture_value_two,
	// interrupt
	output logic timer_irq
);

	localparam int OSC2_W = $clog2(OSC2_DIV);
	localparam logic [OSC2_W-1:0] OSC2_END = OSC2_W'(OSC2_DIV - 1);

	logic [timer8_pkg::PRESC_W-1:0] presc_reg;
	logic [OSC2_W-1:0] osc2_cnt_reg, osc2_cnt_next;
	logic [7:0] count_reg, count_next, count_inc;
	logic [7:0] cmp1_reg, cmp2_reg, act1_reg, act2_reg, act1_next, act2_next;
	logic [7:0] cap1_reg, cap2_reg, cap1_next, cap2_next;
	logic [7:0] target1, target2;
	logic [timer8_pkg::FLAG_N-1:0] flag_reg, flag_next, arm_reg, arm_next;
	logic [timer8_pkg::FLAG_N-1:0] flag_set, flag_access, flag_clear;
	logic pin1_reg, pin1_next, pin2_reg, pin2_next;
	logic oe1_n_reg, oe2_n_reg, irq_reg;
	logic halt_arm1_reg, halt_arm2_reg;
	timer8_pkg::mode_t mode;
	logic cap1_rise, cap1_fall, cap2_rise, cap2_fall, osc2_rise;
	logic cap1_edge, cap2_edge, cap1_take, cap2_take;
	logic tick_mclk, tick_osc2, tick, run, div2;
	logic hit1, hit2, trigger, wake1, wake2, overflow;

	// ----------
	// pin synchronisers
	// ----------
	pin_edge_sync cap1_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin_async(capture_pin_one),
		.rise(cap1_rise),
		.fall(cap1_fall)
	);

	pin_edge_sync cap2_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin_async(capture_pin_two),
		.rise(cap2_rise),
		.fall(cap2_fall)
	);

	pin_edge_sync osc2_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin_async(osc2_clk),
		.rise(osc2_rise),
		.fall()
	);

	// ----------
	// mode decode
	// ----------
	// pwm takes precedence over single pulse
	assign mode = ctrl.pwm_mode_bit ? timer8_pkg::MODE_PWM :
		(ctrl.single_pulse_mode_bit ? timer8_pkg::MODE_SINGLE : timer8_pkg::MODE_COMPARE);
	assign run = ~halt;

	// ----------
	// prescaler and tick selection
	// ----------
	// mclk divider runs freely, ticks taken at its wrap points
	assign tick_mclk = (ctrl.tick_select == timer8_pkg::TICK_DIV2)
		? (presc_reg[0] == timer8_pkg::PRESC_END2[0])
		: (ctrl.tick_select == timer8_pkg::TICK_DIV4)
		? (presc_reg[1:0] == timer8_pkg::PRESC_END4[1:0])
		: (presc_reg == timer8_pkg::PRESC_END8);
	assign tick_osc2 = osc2_rise & (osc2_cnt_reg == OSC2_END);
	assign tick = run & ((ctrl.tick_select == timer8_pkg::TICK_OSC2) ? tick_osc2 : tick_mclk);
	assign osc2_cnt_next = !osc2_rise ? osc2_cnt_reg :
		(osc2_cnt_reg == OSC2_END) ? '0 : osc2_cnt_reg + OSC2_W'(1);
	assign div2 = (ctrl.tick_select == timer8_pkg::TICK_DIV2);

	// ----------
	// compare targets and match events
	// ----------
	// slow ticks see the event one count later than div 2
	assign target1 = div2 ? act1_reg : act1_reg + 8'h01;
	assign target2 = div2 ? act2_reg : act2_reg + 8'h01;
	assign count_inc = count_reg + 8'h01;
	assign hit1 = tick & (count_inc == target1);
	assign hit2 = tick & (count_inc == target2);
	assign overflow = tick & (count_reg == timer8_pkg::COUNT_LAST);

	// ----------
	// capture edges
	// ----------
	assign cap1_edge = ctrl.edge_select_one ? cap1_rise : cap1_fall;
	assign cap2_edge = ctrl.edge_select_two ? cap2_rise : cap2_fall;
	// pin one triggers a pulse in single mode and is cut off in pwm
	assign trigger = run & cap1_edge & (mode == timer8_pkg::MODE_SINGLE);
	assign cap1_take = run & cap1_edge & (mode == timer8_pkg::MODE_COMPARE);
	assign cap2_take = run & cap2_edge;
	// armed captures complete on an interrupt wake from halt
	assign wake1 = wake_irq & halt_arm1_reg;
	assign wake2 = wake_irq & halt_arm2_reg;

	// ----------
	// counter next value
	// ----------
	always_comb begin
		count_next = count_reg;
		if (acc.count_write) begin
			count_next = timer8_pkg::COUNT_PRESET;
		end else if (trigger) begin
			count_next = timer8_pkg::COUNT_PRESET;
		end else if (hit2 && mode == timer8_pkg::MODE_PWM) begin
			count_next = timer8_pkg::COUNT_PRESET;
		end else if (tick) begin
			count_next = count_inc;
		end
	end

	// ----------
	// compare values in use
	// ----------
	// pwm holds new writes until the period ends
	always_comb begin
		act1_next = act1_reg;
		act2_next = act2_reg;
		if (mode != timer8_pkg::MODE_PWM || hit2) begin
			act1_next = cmp1_reg;
			act2_next = cmp2_reg;
		end
	end

	// ----------
	// capture registers
	// ----------
	assign cap1_next = trigger ? timer8_pkg::SINGLE_PULSE_CAPTURE[7:0] :
		(cap1_take | wake1) ? count_reg : cap1_reg;
	assign cap2_next = (cap2_take | wake2) ? count_reg : cap2_reg;

	// ----------
	// flag set sources
	// ----------
	assign flag_set[timer8_pkg::FLAG_CAP1] = cap1_take | trigger | wake1 |
		(hit2 & (mode == timer8_pkg::MODE_PWM));
	assign flag_set[timer8_pkg::FLAG_CMP1] = hit1 & (mode == timer8_pkg::MODE_COMPARE);
	assign flag_set[timer8_pkg::FLAG_OVF] = overflow;
	assign flag_set[timer8_pkg::FLAG_CAP2] = cap2_take | wake2;
	assign flag_set[timer8_pkg::FLAG_CMP2] = hit2 & (mode != timer8_pkg::MODE_PWM);

	// ----------
	// two-step flag clearing
	// ----------
	assign flag_access[timer8_pkg::FLAG_CAP1] = acc.cap1_access;
	assign flag_access[timer8_pkg::FLAG_CMP1] = acc.cmp1_access | acc.cmp1_write;
	assign flag_access[timer8_pkg::FLAG_OVF] = acc.count_access | acc.count_write;
	assign flag_access[timer8_pkg::FLAG_CAP2] = acc.cap2_access;
	assign flag_access[timer8_pkg::FLAG_CMP2] = acc.cmp2_access | acc.cmp2_write;
	// a status read with the flag set arms it, the matching access clears it
	assign flag_clear = arm_reg & flag_access;
	// a new event in the clearing cycle wins
	assign flag_next = flag_set | (flag_reg & ~flag_clear);
	assign arm_next = (acc.status_read ? flag_reg : '0) | (arm_reg & ~flag_access & flag_reg);

	// ----------
	// compare pin one latch
	// ----------
	// matches update the latch whatever the enable, the enable gates the pin and the force
	always_comb begin
		pin1_next = pin1_reg;
		unique case (mode)
			timer8_pkg::MODE_COMPARE: begin
				if (ctrl.force_level_one && ctrl.compare_pin_enable_one) begin
					pin1_next = ctrl.level_after_match_one;
				end else if (hit1) begin
					pin1_next = ctrl.level_after_match_one;
				end
			end
			timer8_pkg::MODE_SINGLE: begin
				if (trigger) begin
					pin1_next = ctrl.level_second;
				end else if (hit1) begin
					pin1_next = ctrl.level_after_match_one;
				end
			end
			timer8_pkg::MODE_PWM: begin
				if (hit2) begin
					pin1_next = ctrl.level_second;
				end else if (hit1) begin
					pin1_next = ctrl.level_after_match_one;
				end
			end
			default: begin
				pin1_next = pin1_reg;
			end
		endcase
	end

	// ----------
	// compare pin two latch
	// ----------
	// only plain compare mode drives a waveform on pin two
	always_comb begin
		pin2_next = pin2_reg;
		if (mode == timer8_pkg::MODE_COMPARE) begin
			if (ctrl.force_level_two && ctrl.compare_pin_enable_two) begin
				pin2_next = ctrl.level_second;
			end else if (hit2) begin
				pin2_next = ctrl.level_second;
			end
		end
	end

	// ----------
	// timer state
	// ----------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			presc_reg <= '0;
			osc2_cnt_reg <= '0;
			count_reg <= timer8_pkg::COUNT_PRESET;
			act1_reg <= timer8_pkg::COMPARE_RESET;
			act2_reg <= timer8_pkg::COMPARE_RESET;
		end else begin
			presc_reg <= run ? presc_reg + 3'h1 : presc_reg;
			osc2_cnt_reg <= run ? osc2_cnt_next : osc2_cnt_reg;
			count_reg <= count_next;
			act1_reg <= act1_next;
			act2_reg <= act2_next;
		end
	end

	// ----------
	// software-visible registers
	// ----------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmp1_reg <= timer8_pkg::COMPARE_RESET;
			cmp2_reg <= timer8_pkg::COMPARE_RESET;
			cap1_reg <= timer8_pkg::CAPTURE_RESET;
			cap2_reg <= timer8_pkg::CAPTURE_RESET;
			flag_reg <= '0;
			arm_reg <= '0;
		end else begin
			cmp1_reg <= acc.cmp1_write ? write_data : cmp1_reg;
			cmp2_reg <= acc.cmp2_write ? write_data : cmp2_reg;
			cap1_reg <= cap1_next;
			cap2_reg <= cap2_next;
			flag_reg <= flag_next;
			arm_reg <= arm_next;
		end
	end

	// ----------
	// halt capture arming
	// ----------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			halt_arm1_reg <= 1'b0;
			halt_arm2_reg <= 1'b0;
		end else begin
			halt_arm1_reg <= halt ? (halt_arm1_reg | (cap1_edge & mode == timer8_pkg::MODE_COMPARE))
				: 1'b0;
			halt_arm2_reg <= halt ? (halt_arm2_reg | cap2_edge) : 1'b0;
		end
	end

	// ----------
	// pins and interrupt
	// ----------
	// pin latches are low from reset; enable clear releases the pin
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pin1_reg <= 1'b0;
			pin2_reg <= 1'b0;
			oe1_n_reg <= 1'b1;
			oe2_n_reg <= 1'b1;
			irq_reg <= 1'b0;
		end else begin
			pin1_reg <= pin1_next;
			pin2_reg <= pin2_next;
			oe1_n_reg <= ~ctrl.compare_pin_enable_one;
			oe2_n_reg <= ~ctrl.compare_pin_enable_two;
			irq_reg <= (ctrl.capture_irq_enable & (flag_next[timer8_pkg::FLAG_CAP1] |
				flag_next[timer8_pkg::FLAG_CAP2])) |
				(ctrl.compare_irq_enable & (flag_next[timer8_pkg::FLAG_CMP1] |
				flag_next[timer8_pkg::FLAG_CMP2])) |
				(ctrl.overflow_irq_enable & flag_next[timer8_pkg::FLAG_OVF]);
		end
	end

	// ----------
	// output wiring
	// ----------
	assign compare_out_pin_one = pin1_reg;
	assign compare_out_pin_one_oe_n = oe1_n_reg;
	assign compare_out_pin_two = pin2_reg;
	assign compare_out_pin_two_oe_n = oe2_n_reg;
	assign status = flag_reg;
	assign count = count_reg;
	assign compare_value_one = cmp1_reg;
	assign compare_value_two = cmp2_reg;
	assign capture_value_one = cap1_reg;
	assign capture_value_two = cap2_reg;
	assign timer_irq = irq_reg;

endmodule

`default_nettype wire

//--- rtl/timer8_pkg.sv
// shared constants, types and encodings of the 8-bit timer compare, pulse and pwm section
// assumes a single clock and the control bits driven as plain ports by the cpu side
package timer8_pkg;

	// ----------------------------------------------------------------
	// counter and register values
	// ----------------------------------------------------------------
	localparam logic [7:0] COUNT_PRESET = 8'hFC;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [7:0] CAPTURE_RESET = 8'h00;
	localparam logic [15:0] SINGLE_PULSE_CAPTURE = 16'hFFFD;
	localparam logic [7:0] COUNT_LAST = 8'hFF;

	// ----------------------------------------------------------------
	// tick select codes and prescaler masks
	// ----------------------------------------------------------------
	localparam logic [1:0] TICK_DIV4 = 2'h0;
	localparam logic [1:0] TICK_DIV2 = 2'h1;
	localparam logic [1:0] TICK_DIV8 = 2'h2;
	localparam logic [1:0] TICK_OSC2 = 2'h3;
	localparam int PRESC_W = 3;
	localparam logic [2:0] PRESC_END2 = 3'h1;
	localparam logic [2:0] PRESC_END4 = 3'h3;
	localparam logic [2:0] PRESC_END8 = 3'h7;
	localparam int OSC2_DIVIDE = 8000;

	// ----------------------------------------------------------------
	// status flag positions within the flag vector
	// ----------------------------------------------------------------
	localparam int FLAG_CAP1 = 4;
	localparam int FLAG_CMP1 = 3;
	localparam int FLAG_OVF = 2;
	localparam int FLAG_CAP2 = 1;
	localparam int FLAG_CMP2 = 0;
	localparam int FLAG_N = 5;

	// operating mode of the compare section
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_PWM = 2'b10
	} mode_t;

	// control bits written by software
	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic force_level_two;
		logic force_level_one;
		logic level_second;
		logic edge_select_one;
		logic level_after_match_one;
		logic compare_pin_enable_one;
		logic compare_pin_enable_two;
		logic single_pulse_mode_bit;
		logic pwm_mode_bit;
		logic [1:0] tick_select;
		logic edge_select_two;
	} ctrl_t;

	// one-cycle software access strobes
	typedef struct packed {
		logic status_read;
		logic cmp1_access;
		logic cmp2_access;
		logic cmp1_write;
		logic cmp2_write;
		logic cap1_access;
		logic cap2_access;
		logic count_access;
		logic count_write;
	} access_t;

	// sticky event flags as seen by software
	typedef struct packed {
		logic capture_flag_one;
		logic compare_flag_one;
		logic overflow_flag;
		logic capture_flag_two;
		logic compare_flag_two;
	} status_t;

endpackage

//--- rtl/pin_edge_sync.sv
// three-stage synchroniser with edge detection for one asynchronous pin
// assumes the pin is unrelated to mclk; edges appear two to three cycles late
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// pin side
	input wire logic pin_async,
	// detected edges
	output logic rise,
	output logic fall
);

	logic s1_reg, s2_reg, s3_reg, level_reg;
	logic agree;

	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			s1_reg <= pin_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree) begin
				level_reg <= s3_reg;
			end
		end
	end

	// a change counts once the last two stages agree
	assign agree = (s2_reg == s3_reg);
	assign rise = agree & s3_reg & ~level_reg;
	assign fall = agree & ~s3_reg & level_reg;

endmodule

`default_nettype wire

//--- tb/pin_side_model.sv
// far side of the timer: capture pin pulses and resolved compare pin lines
// assumes fire strobes come from the bench on mclk; released lines are pulled up
`timescale 1ns/1ps
`default_nettype none

module pin_side_model (
	// clock
	input wire logic mclk,
	// commands from the bench
	input wire logic fire_one,
	input wire logic fire_two,
	// timer pins
	output logic capture_pin_one,
	output logic capture_pin_two,
	input wire logic compare_out_pin_one,
	input wire logic compare_out_pin_one_oe_n,
	input wire logic compare_out_pin_two,
	input wire logic compare_out_pin_two_oe_n,
	// resolved lines
	output logic line_one,
	output logic line_two
);
	// ----------------------------------------------------------------
	// pulse generation and line resolution
	// ----------------------------------------------------------------
	int left_one = 0;
	int left_two = 0;

	// each fire gives an eight cycle high pulse, so both edges reach the timer
	always @(posedge mclk) begin
		left_one <= fire_one ? 8 : left_one - int'(left_one > 0);
		left_two <= fire_two ? 8 : left_two - int'(left_two > 0);
	end

	assign capture_pin_one = left_one > 0;
	assign capture_pin_two = left_two > 0;
	// a released pin is general i/o and floats to the pull-up
	assign line_one = compare_out_pin_one_oe_n ? 1'h1 : compare_out_pin_one;
	assign line_two = compare_out_pin_two_oe_n ? 1'h1 : compare_out_pin_two;
endmodule
`default_nettype wire

//--- tb/timer8_compare_pulse_pwm_asserts.sv
// concurrent checks on the ports of the timer compare, pulse and pwm section
// assumes it is bound to the top module and sees its clock and reset
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_pulse_pwm_asserts #(
	parameter int OSC2_DIV = 8000
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// inputs watched
	input wire timer8_pkg::ctrl_t ctrl,
	input wire timer8_pkg::access_t acc,
	input wire logic halt,
	// outputs watched
	input wire timer8_pkg::status_t status,
	input wire logic [7:0] count,
	input wire logic [7:0] compare_value_one,
	input wire logic [7:0] capture_value_one,
	input wire logic compare_out_pin_one,
	input wire logic compare_out_pin_one_oe_n,
	input wire logic timer_irq
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_match_div2: assert property (
		$rose(status.compare_flag_one) && $past(ctrl.tick_select) == timer8_pkg::TICK_DIV2
		|-> count == compare_value_one) else $error("flag one rose off match at div2");
	a_match_slow: assert property (
		$rose(status.compare_flag_one) && $past(ctrl.tick_select) != timer8_pkg::TICK_DIV2
		|-> count == 8'(compare_value_one + 8'h01)) else $error("flag one rose off match");
	a_pwm_no_cmp: assert property (
		$rose(status.compare_flag_one) || $rose(status.compare_flag_two)
		|-> !$past(ctrl.pwm_mode_bit)) else $error("compare flag set in pwm");
	a_single_no_flag: assert property (
		$rose(status.compare_flag_one) |-> !$past(ctrl.single_pulse_mode_bit))
		else $error("compare flag one set in single pulse");
	a_single_start: assert property (
		$rose(status.capture_flag_one) && $past(ctrl.single_pulse_mode_bit)
		&& !$past(ctrl.pwm_mode_bit) |-> count == timer8_pkg::COUNT_PRESET
		&& capture_value_one == timer8_pkg::SINGLE_PULSE_CAPTURE[7:0]
		&& compare_out_pin_one == $past(ctrl.level_second)) else $error("bad pulse start");
	a_pwm_period: assert property (
		$rose(status.capture_flag_one) && $past(ctrl.pwm_mode_bit)
		|-> count == timer8_pkg::COUNT_PRESET
		&& compare_out_pin_one == $past(ctrl.level_second)) else $error("bad pwm period end");
	a_oe_follows: assert property (
		compare_out_pin_one_oe_n == !$past(ctrl.compare_pin_enable_one))
		else $error("pin one enable not followed");
	a_irq_level: assert property (
		timer_irq == ((status.capture_flag_one || status.capture_flag_two)
		&& $past(ctrl.capture_irq_enable) || (status.compare_flag_one
		|| status.compare_flag_two) && $past(ctrl.compare_irq_enable)
		|| status.overflow_flag && $past(ctrl.overflow_irq_enable)))
		else $error("interrupt does not match enabled flags");
	a_halt_hold: assert property (
		$past(halt) && !$past(acc.count_write) |-> count == $past(count))
		else $error("count moved in halt");
	a_flag_clear: assert property (
		$fell(status.compare_flag_one) |-> $past(acc.cmp1_access || acc.cmp1_write))
		else $error("flag one cleared without access");
endmodule
`default_nettype wire

//--- tb/timer8_compare_pulse_pwm_bench.sv
// self-checking bench for the timer compare, pulse and pwm section
// assumes design, pin side model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_pulse_pwm_bench;
	// ----------------------------------------------------------------
	// signals, rows and helpers
	// ----------------------------------------------------------------
	typedef struct packed {logic [1:0] sel; logic [7:0] val; logic [7:0] hit; logic lvl;} row_t;
	row_t rows [4] = '{'{timer8_pkg::TICK_DIV2, 8'h02, 8'h02, 1'h1},
		'{timer8_pkg::TICK_DIV4, 8'h01, 8'h02, 1'h0}, '{timer8_pkg::TICK_DIV8, 8'h00, 8'h01, 1'h1},
		'{timer8_pkg::TICK_OSC2, 8'hFD, 8'hFE, 1'h0}};
	logic mclk = 1'h0;
	logic arst_n = 1'h0;
	logic osc2_clk = 1'h0;
	timer8_pkg::ctrl_t ctrl = '0;
	timer8_pkg::access_t acc = '0;
	logic [7:0] write_data = 8'h00;
	logic halt = 1'h0;
	logic wake_irq = 1'h0;
	logic fire_one = 1'h0;
	logic fire_two = 1'h0;
	wire logic cap_one, cap_two, pin_one, oe_one_n, pin_two, oe_two_n, line_one, line_two;
	logic irq;
	timer8_pkg::status_t status;
	logic [7:0] count, cv1, cv2, iv1, iv2, prev, held;
	int n_fail = 0;
	int checks = 0;
	int i;

	initial begin
		forever #50 mclk = ~mclk;
	end
	initial begin
		forever #370 osc2_clk = ~osc2_clk;
	end

	timer8_compare_pulse_pwm #(.OSC2_DIV(4)) timer8_compare_pulse_pwm_inst (
		.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl), .acc(acc), .write_data(write_data),
		.halt(halt), .wake_irq(wake_irq), .osc2_clk(osc2_clk), .capture_pin_one(cap_one),
		.capture_pin_two(cap_two), .compare_out_pin_one(pin_one),
		.compare_out_pin_one_oe_n(oe_one_n), .compare_out_pin_two(pin_two),
		.compare_out_pin_two_oe_n(oe_two_n), .status(status), .count(count),
		.compare_value_one(cv1), .compare_value_two(cv2), .capture_value_one(iv1),
		.capture_value_two(iv2), .timer_irq(irq));
	pin_side_model pin_side_model_inst (.mclk(mclk), .fire_one(fire_one), .fire_two(fire_two),
		.capture_pin_one(cap_one), .capture_pin_two(cap_two), .compare_out_pin_one(pin_one),
		.compare_out_pin_one_oe_n(oe_one_n), .compare_out_pin_two(pin_two),
		.compare_out_pin_two_oe_n(oe_two_n), .line_one(line_one), .line_two(line_two));

	task test_done;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task lim;
		if (i >= 3000) begin
			n_fail++;
			$display("BAD wait expected event seen timeout");
			test_done();
		end
	endtask
	// one cycle software strobe, results settled at the following negedge
	// a is the access bit pattern: status_read bit 8 down to count_write bit 0
	task strobe(input timer8_pkg::access_t a, input logic [7:0] d);
		@(posedge mclk);
		acc <= a;
		write_data <= d;
		@(posedge mclk);
		acc <= '0;
		@(negedge mclk);
	endtask
	task fire(input logic two);
		@(posedge mclk);
		fire_one <= !two;
		fire_two <= two;
		@(posedge mclk);
		fire_one <= 1'h0;
		fire_two <= 1'h0;
	endtask
	function automatic logic cur(input int w);
		case (w)
			0: return status.compare_flag_one;
			1: return status.capture_flag_one;
			2: return line_one;
			default: return status.capture_flag_two;
		endcase
	endfunction
	task wait_sig(input int w, input logic v);
		for (i = 0; i < 3000; i++) begin
			@(negedge mclk);
			if (cur(w) === v) break;
		end
		lim();
	endtask
	// waits for the counter to come back to its preset, prev holds the count before
	task wait_wrap;
		for (i = 0; i < 3000; i++) begin
			prev = count;
			@(negedge mclk);
			if (count === timer8_pkg::COUNT_PRESET && prev !== count) break;
		end
		lim();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge mclk);
		arst_n <= 1'h1;
		@(negedge mclk);
		chk("count", timer8_pkg::COUNT_PRESET, count);
		chk("status", 8'h00, 8'(status));
		chk("oe_one_n", 8'h01, 8'(oe_one_n));
		chk("line_two", 8'h01, 8'(line_two));
		$display("test reset done");
		@(posedge mclk);
		ctrl.compare_pin_enable_one <= 1'h1;
		ctrl.compare_irq_enable <= 1'h1;
		foreach (rows[r]) begin
			@(posedge mclk);
			ctrl.tick_select <= rows[r].sel;
			ctrl.level_after_match_one <= rows[r].lvl;
			strobe(9'h021, rows[r].val);
			chk("cv1", rows[r].val, cv1);
			wait_sig(0, 1'h1);
			chk("hit count", rows[r].hit, count);
			chk("line_one", 8'(rows[r].lvl), 8'(line_one));
			chk("irq", 8'h01, 8'(irq));
			strobe(9'h080, 8'h00);
			chk("flag kept", 8'h01, 8'(status.compare_flag_one));
			strobe(9'h100, 8'h00);
			strobe(9'h080, 8'h00);
			chk("flag cleared", 8'h00, 8'(status.compare_flag_one));
			$display("test row %0d done", r);
		end
		@(posedge mclk);
		ctrl.tick_select <= timer8_pkg::TICK_DIV8;
		ctrl.level_after_match_one <= 1'h1;
		ctrl.force_level_one <= 1'h1;
		strobe(9'h021, 8'h80);
		chk("forced high", 8'h01, 8'(line_one));
		@(posedge mclk);
		ctrl.level_after_match_one <= 1'h0;
		repeat (2) @(negedge mclk);
		chk("forced low", 8'h00, 8'(line_one));
		chk("force flag", 8'h00, 8'(status.compare_flag_one));
		$display("test force done");
		@(posedge mclk);
		ctrl.tick_select <= timer8_pkg::TICK_DIV2;
		ctrl.single_pulse_mode_bit <= 1'h1;
		ctrl.edge_select_one <= 1'h1;
		ctrl.level_second <= 1'h1;
		strobe(9'h020, 8'h08);
		fire(1'h0);
		wait_sig(1, 1'h1);
		chk("start count", timer8_pkg::COUNT_PRESET, count);
		chk("start capture", timer8_pkg::SINGLE_PULSE_CAPTURE[7:0], iv1);
		chk("pulse line", 8'h01, 8'(line_one));
		wait_sig(2, 1'h0);
		chk("end count", 8'h08, count);
		chk("no flag one", 8'h00, 8'(status.compare_flag_one));
		fire(1'h1);
		wait_sig(3, 1'h1);
		$display("test single pulse done");
		@(posedge mclk);
		ctrl.pwm_mode_bit <= 1'h1;
		strobe(9'h020, 8'h02);
		strobe(9'h010, 8'h06);
		// the first preset seen may be a plain count-up, the second ends a period
		wait_wrap();
		wait_wrap();
		strobe(9'h100, 8'h00);
		strobe(9'h008, 8'h00);
		strobe(9'h010, 8'h0A);
		wait_wrap();
		chk("old period", 8'h05, prev);
		chk("period line", 8'h01, 8'(line_one));
		chk("period flag", 8'h01, 8'(status.capture_flag_one));
		wait_sig(2, 1'h0);
		chk("pwm match one", 8'h02, count);
		wait_wrap();
		chk("new period", 8'h09, prev);
		chk("cv2", 8'h0A, cv2);
		$display("test pwm done");
		@(posedge mclk);
		ctrl.pwm_mode_bit <= 1'h0;
		ctrl.single_pulse_mode_bit <= 1'h0;
		strobe(9'h100, 8'h00);
		strobe(9'h004, 8'h00);
		@(posedge mclk);
		halt <= 1'h1;
		@(negedge mclk);
		held = count;
		fire(1'h1);
		repeat (16) @(negedge mclk);
		chk("halt count", held, count);
		@(posedge mclk);
		halt <= 1'h0;
		wake_irq <= 1'h1;
		@(posedge mclk);
		wake_irq <= 1'h0;
		@(negedge mclk);
		chk("wake flag", 8'h01, 8'(status.capture_flag_two));
		chk("wake capture", held, iv2);
		$display("test halt done");
		test_done();
	end
endmodule

bind timer8_compare_pulse_pwm timer8_compare_pulse_pwm_asserts #(.OSC2_DIV(OSC2_DIV))
	timer8_compare_pulse_pwm_asserts_inst (.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl),
	.acc(acc), .halt(halt), .status(status), .count(count),
	.compare_value_one(compare_value_one), .capture_value_one(capture_value_one),
	.compare_out_pin_one(compare_out_pin_one),
	.compare_out_pin_one_oe_n(compare_out_pin_one_oe_n), .timer_irq(timer_irq));
`default_nettype wire
